// ==== src/sxd_consts.svh ====
// Constants of the swap/xor/direction-load execution block.
// Assumes inclusion by bare name from design files only.
`ifndef SXD_CONSTS_SVH
`define SXD_CONSTS_SVH

// Direction-load operand codes
`define SXD_DIR_SEL_A      3'h5
`define SXD_DIR_SEL_B      3'h6
`define SXD_DIR_SEL_C      3'h7
// Destination select values
`define SXD_DEST_ACC       1'h0
`define SXD_DEST_FILE      1'h1
// Reset values
`define SXD_ACC_RST        8'h00
`define SXD_DIR_RST        8'hFF
`define SXD_FILE_RST       8'h00
// Highest file address
`define SXD_FILE_MAX       7'h7F

`endif

// ==== src/sxd_pkg.sv ====
// Types of the swap/xor/direction-load execution block.
// Assumes the constants header is compiled alongside.
package sxd_pkg;
   // Operation select
   typedef enum logic [4:0] {
      SXD_OP_NONE = 5'b00001,
      SXD_OP_SWAP = 5'b00010,
      SXD_OP_XORL = 5'b00100,
      SXD_OP_XORF = 5'b01000,
      SXD_OP_DIR  = 5'b10000
   } sxd_op_e;
   typedef logic [7:0] sxd_byte_t;
   typedef logic [6:0] sxd_faddr_t;
endpackage : sxd_pkg

// ==== src/sxd_alu.sv ====
// Combinational result unit: nibble swap and exclusive-OR.
// Assumes operands are stable for the cycle in which they are used.
`timescale 1ns/1ps
`default_nettype none
module sxd_alu
   import sxd_pkg::*;
(
   // Operands
   input  wire sxd_pkg::sxd_op_e   op,
   input  wire sxd_pkg::sxd_byte_t acc,
   input  wire sxd_pkg::sxd_byte_t fval,
   input  wire sxd_pkg::sxd_byte_t lit,
   // Results
   output wire sxd_pkg::sxd_byte_t result,
   output wire logic               zero
);
   // Nibble swap of the file value
   wire sxd_byte_t swapped = {fval[3:0], fval[7:4]};  // RULE_01
   wire sxd_byte_t xl      = acc ^ lit;               // RULE_03
   wire sxd_byte_t xf      = acc ^ fval;              // RULE_05
   assign result = (op == SXD_OP_SWAP) ? swapped :
                   (op == SXD_OP_XORL) ? xl :
                   (op == SXD_OP_XORF) ? xf : acc;
   // Zero detect is shared by both exclusive-OR forms
   assign zero = (result == 8'h00);                   // RULE_07
endmodule // sxd_alu
`default_nettype wire

// ==== src/sxd_exec.sv ====
// Execution unit: swap, xor-literal, xor-file, direction load.
// Assumes a file register array inside; one instruction per cycle.
// Functional notes
// RULE_01: A nibble swap exchanges the two halves of a file register and touches no flag.
// RULE_02: The swap result goes to the accumulator on destination 0, to the file on 1.
// RULE_03: Literal xor combines accumulator and 8-bit literal into the accumulator, zero flag only.
// RULE_04: Direction load copies the accumulator to port A, B or C direction for operand 5, 6, 7.
// RULE_05: File xor combines accumulator and file register, zero flag only.
// RULE_06: The file xor result goes to the accumulator on destination 0, to the file on 1.
// RULE_07: Where the zero flag is updated it is set for a zero result and cleared otherwise.
`include "sxd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sxd_exec
   import sxd_pkg::*;
#(
   parameter int FILE_DEPTH = 128
) (
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               rst,
   // Instruction
   input  wire logic               valid,
   input  wire sxd_pkg::sxd_op_e   op,
   input  wire sxd_pkg::sxd_faddr_t faddr,
   input  wire logic               dest,
   input  wire sxd_pkg::sxd_byte_t lit,
   // State
   output logic [7:0]              acc_q,
   output logic                    zero_q,
   output logic [7:0]              port_a_direction_q,
   output logic [7:0]              port_b_direction_q,
   output logic [7:0]              port_c_direction_q,
   output logic [7:0]              fout_q
);
   // ****************************************************************
   // Checks and storage
   // ****************************************************************
   // The file address is seven bits wide, so exactly 128 entries are reachable
   if (FILE_DEPTH != 128) begin : g_bad_depth
      $error("FILE_DEPTH must be 128");
   end
   sxd_byte_t file_q [FILE_DEPTH];
   wire sxd_byte_t fval = file_q[faddr];
   wire sxd_byte_t result;
   wire            zero;

   sxd_alu u_alu (
      .op     (op),
      .acc    (acc_q),
      .fval   (fval),
      .lit    (lit),
      .result (result),
      .zero   (zero)
   );

   // ****************************************************************
   // Decode
   // ****************************************************************
   wire is_swap  = valid && (op == SXD_OP_SWAP);
   wire is_xorl  = valid && (op == SXD_OP_XORL);
   wire is_xorf  = valid && (op == SXD_OP_XORF);
   wire is_dir   = valid && (op == SXD_OP_DIR);
   // Swap and file xor share the destination choice
   wire to_acc   = is_xorl || ((is_swap || is_xorf) && dest == `SXD_DEST_ACC); // RULE_02 RULE_06
   wire to_file  = (is_swap || is_xorf) && dest == `SXD_DEST_FILE;              // RULE_02 RULE_06
   wire upd_zero = is_xorl || is_xorf;  // Swap leaves the flag alone
   // Operand match for direction loads; the upper address bits must be clear
   function automatic logic dir_match(input sxd_faddr_t a, input logic [2:0] sel);
      return a == {4'h0, sel};
   endfunction
   // Any operand outside 5..7 selects nothing, so such a load is dropped
   wire dir_a    = is_dir && dir_match(faddr, `SXD_DIR_SEL_A);  // RULE_04
   wire dir_b    = is_dir && dir_match(faddr, `SXD_DIR_SEL_B);  // RULE_04
   wire dir_c    = is_dir && dir_match(faddr, `SXD_DIR_SEL_C);  // RULE_04

   // ****************************************************************
   // Accumulator and flag
   // ****************************************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         acc_q  <= `SXD_ACC_RST;
         zero_q <= 1'b0;
      end else begin
         if (to_acc) acc_q <= result;     // RULE_03
         if (upd_zero) zero_q <= zero;    // RULE_07
      end
   end

   // Direction registers reset to all inputs, the safe pin state
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         port_a_direction_q <= `SXD_DIR_RST;
         port_b_direction_q <= `SXD_DIR_RST;
         port_c_direction_q <= `SXD_DIR_RST;
      end else begin
         if (dir_a) port_a_direction_q <= acc_q;  // RULE_04
         if (dir_b) port_b_direction_q <= acc_q;  // RULE_04
         if (dir_c) port_c_direction_q <= acc_q;  // RULE_04
      end
   end

   // File array clears on reset so the first read-modify-write sees known data;
   // the cost is a reset net on every byte, which plain storage would not need
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < FILE_DEPTH; i++) begin
            file_q[i] <= `SXD_FILE_RST;
         end
      end else if (to_file) begin
         file_q[faddr] <= result;  // RULE_01
      end
   end

   // Registered read-back of the addressed file register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) fout_q <= `SXD_FILE_RST;
      else     fout_q <= to_file ? result : fval;
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Swap into the accumulator takes the file value with its halves exchanged
   property p_swap_acc;
      @(posedge clock) disable iff (rst)
      (is_swap && dest == 1'b0) |=> acc_q == {$past(fval[3:0]), $past(fval[7:4])};
   endproperty
   a_swap_acc: assert property (p_swap_acc) else $error("swap to acc wrong"); // RULE_02

   // Swap into the accumulator must not write the file register
   property p_swap_keep;
      @(posedge clock) disable iff (rst)
      (is_swap && dest == 1'b0) |=> fout_q == $past(fval);
   endproperty
   a_swap_keep: assert property (p_swap_keep) else $error("swap to acc wrote file"); // RULE_02

   // Swap back into the file writes the exchanged halves and spares the accumulator
   property p_swap_file;
      @(posedge clock) disable iff (rst)
      (is_swap && dest == 1'b1) |=>
         fout_q == {$past(fval[3:0]), $past(fval[7:4])} && $stable(acc_q);
   endproperty
   a_swap_file: assert property (p_swap_file) else $error("swap to file wrong"); // RULE_01

   // Swap never touches the zero flag, whichever destination it picks
   property p_swap_flag;
      @(posedge clock) disable iff (rst) is_swap |=> $stable(zero_q);
   endproperty
   a_swap_flag: assert property (p_swap_flag) else $error("swap moved flag"); // RULE_01

   // Literal xor lands in the accumulator
   property p_xorl;
      @(posedge clock) disable iff (rst) is_xorl |=> acc_q == ($past(acc_q) ^ $past(lit));
   endproperty
   a_xorl: assert property (p_xorl) else $error("literal xor wrong"); // RULE_03

   // Literal xor has no file destination, so the addressed byte stays put
   property p_xorl_file;
      @(posedge clock) disable iff (rst) is_xorl |=> fout_q == $past(fval);
   endproperty
   a_xorl_file: assert property (p_xorl_file) else $error("literal xor wrote file"); // RULE_03

   // Port A direction takes the accumulator for its own operand
   property p_dir_a;
      @(posedge clock) disable iff (rst)
      (is_dir && faddr == {4'h0, `SXD_DIR_SEL_A}) |=> port_a_direction_q == $past(acc_q);
   endproperty
   a_dir_a: assert property (p_dir_a) else $error("dir A not loaded"); // RULE_04

   // Port B direction takes the accumulator for its own operand
   property p_dir_b;
      @(posedge clock) disable iff (rst) dir_b |=> port_b_direction_q == $past(acc_q);
   endproperty
   a_dir_b: assert property (p_dir_b) else $error("dir B not loaded"); // RULE_04

   // Port C direction takes the accumulator for its own operand
   property p_dir_c;
      @(posedge clock) disable iff (rst)
      (is_dir && faddr == {4'h0, `SXD_DIR_SEL_C}) |=> port_c_direction_q == $past(acc_q);
   endproperty
   a_dir_c: assert property (p_dir_c) else $error("dir C not loaded"); // RULE_04

   // Operands outside 5..7 leave every direction register alone
   property p_dir_refuse;
      @(posedge clock) disable iff (rst)
      (is_dir && !(faddr inside {7'h05, 7'h06, 7'h07})) |=>
         $stable(port_a_direction_q) && $stable(port_b_direction_q) &&
         $stable(port_c_direction_q);
   endproperty
   a_dir_refuse: assert property (p_dir_refuse) else $error("dir load took bad operand"); // RULE_04

   // A direction load moves no flag and keeps the accumulator
   property p_dir_flag;
      @(posedge clock) disable iff (rst) is_dir |=> $stable(zero_q) && $stable(acc_q);
   endproperty
   a_dir_flag: assert property (p_dir_flag) else $error("dir load changed state"); // RULE_04

   // File xor into the accumulator
   property p_xorf_acc;
      @(posedge clock) disable iff (rst)
      (is_xorf && dest == 1'b0) |=> acc_q == ($past(acc_q) ^ $past(fval));
   endproperty
   a_xorf_acc: assert property (p_xorf_acc) else $error("file xor acc wrong"); // RULE_05

   // File xor back into the file spares the accumulator
   property p_xorf_file;
      @(posedge clock) disable iff (rst)
      (is_xorf && dest == 1'b1) |=> fout_q == ($past(acc_q) ^ $past(fval)) && $stable(acc_q);
   endproperty
   a_xorf_file: assert property (p_xorf_file) else $error("file xor file wrong"); // RULE_06

   // Zero flag follows the xor result, worked out here from the operands themselves
   property p_zero;
      @(posedge clock) disable iff (rst)
      upd_zero |=> zero_q == ($past(is_xorl ? (acc_q ^ lit) : (acc_q ^ fval)) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong"); // RULE_07

   // ****************************************************************
   // Covers
   // ****************************************************************
   // Main paths that the bench is expected to reach
   c_swap_file: cover property (@(posedge clock) is_swap && dest == 1'b1);
   c_xorl_zero: cover property (@(posedge clock) is_xorl && zero);
   c_xorf_file: cover property (@(posedge clock) is_xorf && dest == 1'b1);
   c_dir_c:     cover property (@(posedge clock) dir_c);
endmodule // sxd_exec
`default_nettype wire

// ==== tb/swap_xor_dirload_exec_tb.sv ====
// Self-checking testbench for the swap/xor/direction-load execution unit.
// Assumes sxd_pkg and sxd_exec are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module swap_xor_dirload_exec_tb;
   import sxd_pkg::*;
   // ****************************************************************
   // Stimulus, design under test and checks
   // ****************************************************************
   logic       clock = 1'b0;
   logic       rst   = 1'b1;
   logic       valid = 1'b0;
   sxd_op_e    op    = SXD_OP_NONE;
   sxd_faddr_t faddr = 7'h00;
   logic       dest  = 1'b0;
   sxd_byte_t  lit   = 8'h00;
   wire logic [7:0] acc_q, pa_q, pb_q, pc_q, fout_q;
   wire logic       zero_q;
   int n_errors   = 0;
   int num_checks = 0;
   int cycles     = 0;

   sxd_exec i_dut (.clock(clock), .rst(rst), .valid(valid), .op(op), .faddr(faddr),
      .dest(dest), .lit(lit), .acc_q(acc_q), .zero_q(zero_q), .port_a_direction_q(pa_q),
      .port_b_direction_q(pb_q), .port_c_direction_q(pc_q), .fout_q(fout_q));

   // Free-running 100 MHz clock
   always #5 clock = ~clock;

   // Cut a hang short; the whole run needs well under 100 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 1000) begin
         n_errors++;
         $display("unexpected at %0t: run did not finish", $time);
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // Compare accumulator, zero flag and all three direction registers
   task automatic state(input logic [7:0] acc, input logic z, input logic [7:0] a, b, c);
      chk(acc_q, acc, "accumulator");
      chk({7'h00, zero_q}, {7'h00, z}, "zero flag");
      chk(pa_q, a, "port a direction");
      chk(pb_q, b, "port b direction");
      chk(pc_q, c, "port c direction");
   endtask

   // Present one instruction for one edge; valid is driven from v and left there so calls can run back to back
   task automatic instr(input sxd_op_e o, input logic [6:0] a, input logic d,
                        input logic [7:0] k, input logic v);
      valid = v;
      op = o;
      faddr = a;
      dest = d;
      lit = k;
      @(posedge clock);
      #1;
   endtask

   task automatic do_reset();
      valid = 1'b0;
      op = SXD_OP_NONE;
      rst = 1'b1;
      repeat (3) @(posedge clock);
      #1 rst = 1'b0;
   endtask

   // Direction loads for operands 5..7 with distinct accumulator values, then refusals
   task automatic t_dir();
      instr(SXD_OP_XORL, 7'h00, 1'b0, 8'h11, 1'b1);
      instr(SXD_OP_DIR, 7'h05, 1'b0, 8'h00, 1'b1);
      instr(SXD_OP_XORL, 7'h00, 1'b0, 8'h22, 1'b1);
      instr(SXD_OP_DIR, 7'h06, 1'b0, 8'h00, 1'b1);
      instr(SXD_OP_XORL, 7'h00, 1'b0, 8'h44, 1'b1);
      instr(SXD_OP_DIR, 7'h07, 1'b0, 8'h00, 1'b1);
      state(8'h88, 1'b0, 8'hEE, 8'hCC, 8'h88);
      instr(SXD_OP_DIR, 7'h04, 1'b0, 8'h00, 1'b1);
      instr(SXD_OP_DIR, 7'h0D, 1'b0, 8'h00, 1'b1);
      instr(SXD_OP_NONE, 7'h05, 1'b0, 8'h00, 1'b1);
      instr(SXD_OP_XORL, 7'h00, 1'b0, 8'h88, 1'b0);
      state(8'h88, 1'b0, 8'hEE, 8'hCC, 8'h88);
   endtask

   // File operations that write back leave the accumulator and, for swap, the flag alone
   task automatic t_file();
      instr(SXD_OP_XORL, 7'h00, 1'b0, 8'h2D, 1'b1);
      instr(SXD_OP_XORF, 7'h7F, 1'b1, 8'h00, 1'b1);
      chk(fout_q, 8'hA5, "file after xor write-back");
      state(8'hA5, 1'b0, 8'hEE, 8'hCC, 8'h88);
      instr(SXD_OP_SWAP, 7'h7F, 1'b1, 8'h00, 1'b1);
      chk(fout_q, 8'h5A, "file after swap write-back");
      instr(SXD_OP_XORL, 7'h00, 1'b0, 8'hA5, 1'b1);
      instr(SXD_OP_SWAP, 7'h7F, 1'b0, 8'h00, 1'b1);
      state(8'hA5, 1'b1, 8'hEE, 8'hCC, 8'h88);
      chk(fout_q, 8'h5A, "file after swap to accumulator");
      instr(SXD_OP_XORF, 7'h7F, 1'b0, 8'h00, 1'b1);
      state(8'hFF, 1'b0, 8'hEE, 8'hCC, 8'h88);
      chk(fout_q, 8'h5A, "file after xor to accumulator");
      instr(SXD_OP_XORL, 7'h00, 1'b0, 8'hA5, 1'b1);
      instr(SXD_OP_XORF, 7'h7F, 1'b0, 8'h00, 1'b1);
      state(8'h00, 1'b1, 8'hEE, 8'hCC, 8'h88);
   endtask

   initial begin
      @(posedge clock);
      #1;
      do_reset();
      state(8'h00, 1'b0, 8'hFF, 8'hFF, 8'hFF);
      instr(SXD_OP_XORL, 7'h00, 1'b0, 8'h5A, 1'b1);
      chk({7'h00, zero_q}, 8'h00, "zero flag clear");
      instr(SXD_OP_XORL, 7'h00, 1'b0, 8'h5A, 1'b1);
      state(8'h00, 1'b1, 8'hFF, 8'hFF, 8'hFF);
      instr(SXD_OP_XORL, 7'h00, 1'b0, 8'hFF, 1'b1);
      state(8'hFF, 1'b0, 8'hFF, 8'hFF, 8'hFF);
      t_dir();
      t_file();
      do_reset();
      state(8'h00, 1'b0, 8'hFF, 8'hFF, 8'hFF);
      chk(fout_q, 8'h00, "file read-back after reset");
      instr(SXD_OP_XORL, 7'h00, 1'b0, 8'h00, 1'b1);
      instr(SXD_OP_SWAP, 7'h7F, 1'b0, 8'h00, 1'b1);
      chk({7'h00, zero_q}, 8'h01, "zero flag after swap");
      chk(acc_q, 8'h00, "accumulator after swap of cleared file");
      close_out();
   end
endmodule // swap_xor_dirload_exec_tb
`default_nettype wire
